/* mmbd_decoder.sv */
// Purpose: memory mode latch, external bus mapping and chip-select predecode
// Assumes: cpu holds an access stable while ext_busy is high
// Notes:   pins use separate out and output enable signals, with inputs on ports a and d only
//          the mode is taken once after reset; moving the pin later has no effect
//          port_cfg is ignored for bus and function pins in processor mode
//          wait is honoured only on a port d pin set to bus control
//
// Behaviour
// - expansion mode: A data, B/C address, D control
// - unused bus pins serve as gpio
// - address and data on separate pins
// - each port d pin picks its function
// - 2000h-3FFFh asserts both low-range selects
// - 8000h-FFFFh asserts enabled high-range selects
// - 10C0h-10FFh asserts peripheral frame select
// - internal expansion areas never go external
// - chip selects share strobe timing
// - strobe low on every external access
// - processor mode keeps register file, nonvolatile
// - processor strobe ranges with memory disabled
// - processor mode forces bus ports, locked
// - no chip selects in bus-control function
// - processor fetches code and vectors externally
// - cleared disable bit maps 4000h-7FFFh inside
// - 1020h-102Fh dead with internal memory
// - disable bit swaps vector memory in/out
// - disable bit reads set after reset
// - mode latched at reset release
// - bus control: fetch flag, strobe, wait
`timescale 1ns/1ns
module mmbd_decoder (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    mode_select_pin,
  input  wire mmbd_pkg::mmbd_access_t  cpu_access,
  input  wire mmbd_pkg::mmbd_port_cfg_t port_cfg,
  input  wire logic                    mem_disable_wr,
  input  wire logic                    mem_disable_wdata,
  input  wire logic [7:0]              port_a_in,
  input  wire logic [7:0]              port_d_in,
  output logic [7:0]                   port_a_out,
  output logic [7:0]                   port_a_oe,
  output logic [7:0]                   port_b_out,
  output logic [7:0]                   port_b_oe,
  output logic [7:0]                   port_c_out,
  output logic [7:0]                   port_c_oe,
  output logic [7:0]                   port_d_out,
  output logic [7:0]                   port_d_oe,
  output logic [7:0]                   ext_rdata,
  output logic                         ext_busy,
  output logic                         ext_selected,
  output logic                         mem_disable,
  output logic                         microprocessor_mode
);
  // synchroniser stages for pins
  logic [7:0]             pa_s1_reg;
  logic [7:0]             pa_s2_reg;
  logic [7:0]             pd_s1_reg;
  logic [7:0]             pd_s2_reg;
  logic                   mc_s1_reg;
  logic                   mc_s2_reg;
  // mode latch and the software disable bit
  logic                   rst_seen_reg;
  logic                   rst_seen_next;
  mmbd_pkg::mmbd_mode_t   mode_reg;
  mmbd_pkg::mmbd_mode_t   mode_next;
  logic                   mem_dis_reg;
  logic                   mem_dis_next;
  // registered pin drive, so no decode glitch reaches a pin
  logic [7:0]             pa_out_reg;
  logic [7:0]             pa_out_next;
  logic [7:0]             pa_oe_reg;
  logic [7:0]             pa_oe_next;
  logic [7:0]             pb_out_reg;
  logic [7:0]             pb_out_next;
  logic [7:0]             pb_oe_reg;
  logic [7:0]             pb_oe_next;
  logic [7:0]             pc_out_reg;
  logic [7:0]             pc_out_next;
  logic [7:0]             pc_oe_reg;
  logic [7:0]             pc_oe_next;
  logic [7:0]             pd_out_reg;
  logic [7:0]             pd_out_next;
  logic [7:0]             pd_oe_reg;
  logic [7:0]             pd_oe_next;
  // access status back to the cpu side
  logic [7:0]             rdata_reg;
  logic [7:0]             rdata_next;
  logic                   sel_reg;
  logic                   sel_next;
  logic                   busy_reg;
  logic                   busy_next;
  // combinational decode results
  logic                   strobe_on;
  logic                   cs_low_hit;
  logic                   cs_high_hit;
  logic                   cs_pf_hit;
  logic                   wait_low;
  mmbd_pkg::mmbd_pin_fn_t d_fn [8];

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // pins cross two flops; the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    pa_s1_reg <= port_a_in;
    pa_s2_reg <= pa_s1_reg;
    pd_s1_reg <= port_d_in;
    pd_s2_reg <= pd_s1_reg;
    mc_s1_reg <= mode_select_pin;
    mc_s2_reg <= mc_s1_reg;
  end

  // functions forced
  // processor mode overrides software: d gets bus control, a/b/c bus
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dfn
      assign d_fn[gi] = (mode_reg == mmbd_pkg::MMBD_MICROPROCESSOR) ? mmbd_pkg::MMBD_FUNC_B :
                        mmbd_pkg::mmbd_pin_fn_t'(port_cfg.d_fn[2*gi +: 2]);
    end
  endgenerate

  // address decode for the strobe and the predecoded selects
  always_comb begin
    strobe_on   = 1'b0;
    cs_low_hit  = 1'b0;
    cs_high_hit = 1'b0;
    cs_pf_hit   = 1'b0;
    if (cpu_access.valid) begin
      case (mode_reg)
        mmbd_pkg::MMBD_MICROPROCESSOR: begin
          strobe_on = in_range(cpu_access.addr, mmbd_pkg::PF_TOP_LO, mmbd_pkg::PF_TOP_HI) ||
                      in_range(cpu_access.addr, mmbd_pkg::LOW_CS_LO, mmbd_pkg::HIGH_CS_HI);
          if (mem_dis_reg) begin
            strobe_on = strobe_on || in_range(cpu_access.addr, mmbd_pkg::PF_EXT_LO, mmbd_pkg::PF_EXT_HI);
          end else if (in_range(cpu_access.addr, mmbd_pkg::PROG_LO, mmbd_pkg::PROG_HI)) begin
            strobe_on = 1'b0;
          end
        end
        mmbd_pkg::MMBD_MICROCOMPUTER: begin
          // internal areas excluded
          // program space stays internal, only the chip-select windows go out
          cs_pf_hit   = in_range(cpu_access.addr, mmbd_pkg::PF_TOP_LO, mmbd_pkg::PF_TOP_HI);
          cs_low_hit  = in_range(cpu_access.addr, mmbd_pkg::LOW_CS_LO, mmbd_pkg::LOW_CS_HI);
          cs_high_hit = in_range(cpu_access.addr, mmbd_pkg::HIGH_CS_LO, mmbd_pkg::HIGH_CS_HI);
          strobe_on   = cs_pf_hit || cs_low_hit || cs_high_hit;
        end
        default: strobe_on = 1'b0;
      endcase
    end
  end

  // wait input
  // wait is sampled only on a pin set to bus control
  assign wait_low = (d_fn[mmbd_pkg::PD_WAIT] == mmbd_pkg::MMBD_FUNC_B) && !pd_s2_reg[mmbd_pkg::PD_WAIT];

  // mode, disable bit and access tracking
  always_comb begin
    rst_seen_next = 1'b1;
    mode_next     = mode_reg;
    mem_dis_next  = mem_dis_reg;
    // latch at release
    // first cycle after reset release captures the synchronised pin
    if (!rst_seen_reg) begin
      mode_next = mc_s2_reg ? mmbd_pkg::MMBD_MICROPROCESSOR : mmbd_pkg::MMBD_MICROCOMPUTER;
    end
    // disable bit only has meaning in processor mode
    if (mem_disable_wr && mode_reg == mmbd_pkg::MMBD_MICROPROCESSOR) begin
      mem_dis_next = mem_disable_wdata;
    end
    sel_next   = strobe_on;
    busy_next  = strobe_on && wait_low;
    rdata_next = strobe_on ? pa_s2_reg : rdata_reg;
  end

  // pin drive computation
  always_comb begin
    pa_out_next = port_cfg.a_gpio_out;
    pa_oe_next  = port_cfg.a_gpio_oe;
    pb_out_next = port_cfg.b_gpio_out;
    pb_oe_next  = port_cfg.b_gpio_oe;
    pc_out_next = port_cfg.c_gpio_out;
    pc_oe_next  = port_cfg.c_gpio_oe;
    pd_out_next = port_cfg.d_gpio_out;
    pd_oe_next  = port_cfg.d_gpio_oe;
    for (int i = 0; i < 8; i++) begin
      // separate buses
      // address and data never share pins, so no external latch
      if (mode_reg == mmbd_pkg::MMBD_MICROPROCESSOR || port_cfg.b_bus_en[i]) begin
        pb_out_next[i] = cpu_access.addr[8+i];
        pb_oe_next[i]  = 1'b1;
      end
      if (mode_reg == mmbd_pkg::MMBD_MICROPROCESSOR || port_cfg.c_bus_en[i]) begin
        pc_out_next[i] = cpu_access.addr[i];
        pc_oe_next[i]  = 1'b1;
      end
      if (mode_reg == mmbd_pkg::MMBD_MICROPROCESSOR || port_cfg.a_bus_en[i]) begin
        pa_out_next[i] = cpu_access.wdata[i];
        pa_oe_next[i]  = strobe_on && cpu_access.write;
      end
      case (d_fn[i])
        mmbd_pkg::MMBD_FUNC_A: begin
          pd_oe_next[i]  = 1'b1;
          pd_out_next[i] = 1'b1;
        end
        mmbd_pkg::MMBD_FUNC_B: begin
          pd_oe_next[i]  = (i == mmbd_pkg::PD_OCF) || (i == mmbd_pkg::PD_EDS);
          pd_out_next[i] = 1'b1;
        end
        default: ;
      endcase
    end
    // chip selects and bus control pins
    // selects and strobe come from the same registered decode
    if (d_fn[mmbd_pkg::PD_LRA] == mmbd_pkg::MMBD_FUNC_A) pd_out_next[mmbd_pkg::PD_LRA] = !cs_low_hit;
    if (d_fn[mmbd_pkg::PD_LRB] == mmbd_pkg::MMBD_FUNC_A) pd_out_next[mmbd_pkg::PD_LRB] = !cs_low_hit;
    if (d_fn[mmbd_pkg::PD_HRA] == mmbd_pkg::MMBD_FUNC_A) pd_out_next[mmbd_pkg::PD_HRA] = !cs_high_hit;
    if (d_fn[mmbd_pkg::PD_HRB] == mmbd_pkg::MMBD_FUNC_A) pd_out_next[mmbd_pkg::PD_HRB] = !cs_high_hit;
    if (d_fn[mmbd_pkg::PD_HRC] == mmbd_pkg::MMBD_FUNC_A) pd_out_next[mmbd_pkg::PD_HRC] = !cs_high_hit;
    if (d_fn[mmbd_pkg::PD_PFS] == mmbd_pkg::MMBD_FUNC_A) pd_out_next[mmbd_pkg::PD_PFS] = !cs_pf_hit;
    if (d_fn[mmbd_pkg::PD_EDS] == mmbd_pkg::MMBD_FUNC_B) pd_out_next[mmbd_pkg::PD_EDS] = !strobe_on;
    if (d_fn[mmbd_pkg::PD_OCF] == mmbd_pkg::MMBD_FUNC_B) begin
      pd_out_next[mmbd_pkg::PD_OCF] = !(strobe_on && cpu_access.fetch);
    end
  end

  // state registers; pins released and selects idle in reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rst_seen_reg <= 1'b0;
      mode_reg     <= mmbd_pkg::MMBD_MICROCOMPUTER;
      mem_dis_reg  <= mmbd_pkg::MEM_DIS_RST;
      pa_out_reg   <= 8'h00;
      pa_oe_reg    <= 8'h00;
      pb_out_reg   <= 8'h00;
      pb_oe_reg    <= 8'h00;
      pc_out_reg   <= 8'h00;
      pc_oe_reg    <= 8'h00;
      pd_out_reg   <= 8'hFF;
      pd_oe_reg    <= 8'h00;
      rdata_reg    <= 8'h00;
      sel_reg      <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      rst_seen_reg <= rst_seen_next;
      mode_reg     <= mode_next;
      mem_dis_reg  <= mem_dis_next;
      pa_out_reg   <= pa_out_next;
      pa_oe_reg    <= pa_oe_next;
      pb_out_reg   <= pb_out_next;
      pb_oe_reg    <= pb_oe_next;
      pc_out_reg   <= pc_out_next;
      pc_oe_reg    <= pc_oe_next;
      pd_out_reg   <= pd_out_next;
      pd_oe_reg    <= pd_oe_next;
      rdata_reg    <= rdata_next;
      sel_reg      <= sel_next;
      busy_reg     <= busy_next;
    end
  end

  // outputs straight from flops
  assign port_a_out          = pa_out_reg;
  assign port_a_oe           = pa_oe_reg;
  assign port_b_out          = pb_out_reg;
  assign port_b_oe           = pb_oe_reg;
  assign port_c_out          = pc_out_reg;
  assign port_c_oe           = pc_oe_reg;
  assign port_d_out          = pd_out_reg;
  assign port_d_oe           = pd_oe_reg;
  assign ext_rdata           = rdata_reg;
  assign ext_busy            = busy_reg;
  assign ext_selected        = sel_reg;
  assign mem_disable         = mem_dis_reg;
  assign microprocessor_mode = logic'(mode_reg);
endmodule

/* mmbd_pkg.sv */
// Purpose: shared constants and types for the memory mode bus decoder
// Assumes: 16-bit cpu address, 8-bit data, port d pins selected per pin
// Notes:   all address windows are inclusive
package mmbd_pkg;
  localparam logic [15:0] PF_EXT_LO   = 16'h1020;
  localparam logic [15:0] PF_EXT_HI   = 16'h102F;
  localparam logic [15:0] PF_TOP_LO   = 16'h10C0;
  localparam logic [15:0] PF_TOP_HI   = 16'h10FF;
  localparam logic [15:0] LOW_CS_LO   = 16'h2000;
  localparam logic [15:0] LOW_CS_HI   = 16'h3FFF;
  localparam logic [15:0] PROG_LO     = 16'h4000;
  localparam logic [15:0] PROG_HI     = 16'h7FFF;
  localparam logic [15:0] HIGH_CS_LO  = 16'h8000;
  localparam logic [15:0] HIGH_CS_HI  = 16'hFFFF;
  localparam logic        MEM_DIS_RST = 1'b1;
  // port d pin indices
  localparam int PD_LRA  = 0;
  localparam int PD_LRB  = 1;
  localparam int PD_HRA  = 2;
  localparam int PD_HRB  = 3;
  localparam int PD_HRC  = 4;
  localparam int PD_PFS  = 5;
  localparam int PD_OCF  = 6;
  localparam int PD_EDS  = 7;
  localparam int PD_WAIT = 5;
  // per-pin function of a port d pin
  typedef enum logic [1:0] {MMBD_GPIO, MMBD_FUNC_A, MMBD_FUNC_B} mmbd_pin_fn_t;
  typedef enum logic {MMBD_MICROCOMPUTER, MMBD_MICROPROCESSOR} mmbd_mode_t;
  // cpu access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mmbd_access_t;
  // software port configuration
  typedef struct packed {
    logic [7:0] a_bus_en;
    logic [7:0] b_bus_en;
    logic [7:0] c_bus_en;
    logic [15:0] d_fn;
    logic [7:0] a_gpio_out;
    logic [7:0] a_gpio_oe;
    logic [7:0] b_gpio_out;
    logic [7:0] b_gpio_oe;
    logic [7:0] c_gpio_out;
    logic [7:0] c_gpio_oe;
    logic [7:0] d_gpio_out;
    logic [7:0] d_gpio_oe;
  } mmbd_port_cfg_t;
endpackage

/* mmbd_chk.sv */
// Purpose: port checks for the memory mode bus decoder
// Assumes: one clock, sync reset, select pins per package map
// Notes:   pins change one cycle after the access is seen
`timescale 1ns/1ns
module mmbd_chk (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire mmbd_pkg::mmbd_access_t   cpu_access,
  input wire mmbd_pkg::mmbd_port_cfg_t port_cfg,
  input wire logic [7:0]               port_b_out,
  input wire logic [7:0]               port_c_out,
  input wire logic [7:0]               port_b_oe,
  input wire logic [7:0]               port_c_oe,
  input wire logic [7:0]               port_d_out,
  input wire logic [7:0]               port_d_oe,
  input wire logic                     mem_disable,
  input wire logic                     microprocessor_mode
);
  logic        mp;
  logic        v;
  logic [15:0] a;
  // short aliases keep the properties readable
  assign mp = microprocessor_mode;
  assign v  = cpu_access.valid;
  assign a  = cpu_access.addr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_low_sel_pair: assert property (!mp && v && a inside {[16'h2000:16'h3FFF]} &&
    port_cfg.d_fn[3:0] == 4'h5 |=> port_d_out[1:0] == 2'h0) else $error("low selects not both low");
  a_high_sel_bank: assert property (!mp && v && a[15] && port_cfg.d_fn[5:4] == 2'h1 |=> !port_d_out[2])
    else $error("high select a not low");
  a_pframe_sel: assert property (!mp && v && a inside {[16'h10C0:16'h10FF]} && port_cfg.d_fn[11:10] == 2'h1
    |=> !port_d_out[5]) else $error("frame select not low");
  a_sel_idle_high: assert property (!mp && !v && port_cfg.d_fn[1:0] == 2'h1 |=> port_d_out[0])
    else $error("select low without access");
  a_sel_strobe_tied: assert property (!mp && port_cfg.d_fn[1:0] == 2'h1 && port_cfg.d_fn[15:14] == 2'h2 &&
    !port_d_out[0] |-> !port_d_out[7]) else $error("select low while strobe high");
  a_proc_strobe_on: assert property (mp && mem_disable && v && a >= 16'h2000 |=> !port_d_out[7])
    else $error("strobe missing in processor mode");
  a_int_mem_quiet: assert property (mp && !mem_disable && v &&
    a inside {[16'h4000:16'h7FFF], [16'h1020:16'h102F]} |=> port_d_out[7]) else $error("strobe on internal range");
  a_addr_split: assert property (mp && mem_disable && v && a[15] |=> {port_b_out, port_c_out} == $past(a))
    else $error("address not on ports b and c");
  a_bus_forced: assert property (mp [*2] |-> port_b_oe == 8'hFF && port_c_oe == 8'hFF &&
    port_d_oe[5:0] == 6'h00) else $error("processor ports not forced");
  a_mode_hold: assert property ($past(rst_n, 3) |-> $stable(microprocessor_mode))
    else $error("mode changed without reset");
  a_reset_values: assert property (rst_n && !$past(rst_n) |-> mem_disable && !mp)
    else $error("reset values wrong");
endmodule
bind mmbd_decoder mmbd_chk u_chk (.sys_clk, .rst_n, .cpu_access, .port_cfg, .port_b_out, .port_c_out,
  .port_b_oe, .port_c_oe, .port_d_out, .port_d_oe, .mem_disable, .microprocessor_mode);

/* mmbd_ext_mem.sv */
// Purpose: external memory and peripheral chips on the expansion bus
// Assumes: strobe low marks an external access
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ns
module mmbd_ext_mem (
  input  wire logic        sys_clk,
  input  wire logic        strobe_n,
  input  wire logic        drive_ok,
  input  wire logic        slow,
  input  wire logic [15:0] addr,
  output logic      [7:0]  data_pin = 8'h00,
  output logic             wait_n = 1'b1
);
  logic [1:0] stall = 2'h0;
  always @(posedge sys_clk) begin
    data_pin <= (!strobe_n && drive_ok) ? (addr[7:0] ^ 8'h5A) : ~data_pin;
    stall    <= strobe_n ? 2'h0 : stall + {1'b0, stall != 2'h2};
    wait_n   <= strobe_n || !slow || stall == 2'h2;  // slow parts stretch two cycles
  end
endmodule

/* memory_mode_bus_decoder_tb_top.sv */
// Purpose: self-checking bench for the memory mode bus decoder
// Assumes: accesses held six cycles, longer while busy
// Notes:   the notes queue holds expected pins for a given cycle
`timescale 1ns/1ns
module memory_mode_bus_decoder_tb_top;
  typedef struct {int cyc; logic [51:0] msk; logic [51:0] exp;} mmbd_note_t;
  logic                     sys_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     mode_select_pin = 1'b0;
  logic                     mem_disable_wr = 1'b0;
  logic                     mem_disable_wdata = 1'b0;
  logic                     slow = 1'b0;
  logic                     mp_e = 1'b0;
  logic                     dis_e = 1'b1;
  logic                     ext_busy, ext_selected, mem_disable, microprocessor_mode, wait_n;
  logic [7:0]               port_a_in, port_d_in, port_a_oe, port_a_out, port_b_out, port_c_out, port_d_out;
  logic [7:0]               ext_rdata;
  mmbd_pkg::mmbd_access_t   cpu_access = '0;
  // pin 3 spare select held as high gpio
  mmbd_pkg::mmbd_port_cfg_t port_cfg = {24'hFFFFFF, 16'hA515, 48'h0, 16'h0808};
  logic [15:0]              tbl [15] = '{16'h2000, 16'h3FFF, 16'h1FFF, 16'h4000, 16'h7FFE, 16'h7FFF, 16'h8000,
                                         16'hFFFF, 16'h10BF, 16'h10C0, 16'h10FF, 16'h1020, 16'h102F, 16'h1030, 16'h0000};
  int                       cyc = 0, n_mismatch = 0, n_compared = 0, seed = 32'h2E6AFAB7;
  mmbd_note_t               q [$];
  assign port_d_in = {2'h3, wait_n, 5'h1F};
  // clock and the cycle count that the notes are keyed on
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  mmbd_decoder dut (.sys_clk, .rst_n, .mode_select_pin, .cpu_access, .port_cfg, .mem_disable_wr, .mem_disable_wdata,
    .port_a_in, .port_d_in, .port_a_out, .port_a_oe, .port_b_out, .port_b_oe(), .port_c_out, .port_c_oe(),
    .port_d_out, .port_d_oe(), .ext_rdata, .ext_busy, .ext_selected, .mem_disable, .microprocessor_mode);
  mmbd_ext_mem u_mem (.sys_clk, .strobe_n(port_d_out[7]), .drive_ok(port_a_oe == 8'h00), .slow,
    .addr({port_b_out, port_c_out}), .data_pin(port_a_in), .wait_n);
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // strobe windows per mode; microcomputer covers the select windows only
  function automatic logic strobe(input logic [15:0] a);
    logic pf;
    pf = a inside {[16'h10C0:16'h10FF]};
    if (!mp_e)
      return pf || a[15] || a inside {[16'h2000:16'h3FFF]};
    if (dis_e)
      return pf || a inside {[16'h1020:16'h102F]} || a >= 16'h2000;
    return pf || (a >= 16'h2000 && !(a inside {[16'h4000:16'h7FFF]}));
  endfunction
  // a note is due dly-1 edges after the current one; cleared mask bits are not looked at
  task automatic note(input int dly, input logic [51:0] msk, input logic [51:0] exp);
    q.push_back('{cyc + dly, msk, exp});
  endtask
  task automatic go(input logic [15:0] a);
    logic       s, lo, pf, f, w, sl;
    logic [7:0] wd, ao, dp;
    int         k;
    s  = strobe(a);
    lo = a inside {[16'h2000:16'h3FFF]};
    pf = a inside {[16'h10C0:16'h10FF]};
    f  = 1'($random(seed));
    w  = 1'($random(seed));
    sl = 1'($random(seed));
    wd = 8'($random(seed));
    ao = (s && w) ? 8'hFF : 8'h00;
    dp = {!s, !(s && f), !pf, !a[15], 1'b1, !a[15], !lo, !lo};
    @(posedge sys_clk);
    cpu_access <= '{1'b1, w, f, a, wd};
    slow       <= sl;
    if (mp_e)
      port_cfg <= mmbd_pkg::mmbd_port_cfg_t'(104'({$random(seed), $random(seed), $random(seed), $random(seed)}));
    // pins, select flag and write drive one edge after the request
    note(2, {2'h1, 8'hFF, ao, 8'h00, 2'h3, mp_e ? 8'hC0 : 8'hFF, s ? 16'hFFFF : 16'h0000},
         {1'b0, s, ao, wd, 8'h00, mp_e, dis_e, dp, a});
    // read data and a slow part's wait need the pin synchronisers to fill
    note(6, {1'b1, 17'h0, (s && !w) ? 8'hFF : 8'h00, 26'h0},
         {mp_e && s && sl, 17'h0, a[7:0] ^ 8'h5A, 26'h0});
    repeat (6) @(posedge sys_clk);
    for (k = 0; k < 20 && ext_busy; k++) @(posedge sys_clk);
    if (k == 20) begin
      n_mismatch++;
      $display("[FAIL] ext_busy exp 0 got 1");
      end_of_test();
    end
    cpu_access.valid <= 1'b0;
    note(2, {2'h1, 8'hFF, 16'h0000, 2'h3, mp_e ? 8'hC0 : 8'hFF, 16'h0000},
         {18'h0, 8'h00, mp_e, dis_e, 8'hFF, 16'h0000});
  endtask
  task automatic restart(input logic p);
    @(posedge sys_clk);
    mode_select_pin <= p;
    rst_n           <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    mp_e  = p;
    dis_e = 1'b1;
    repeat (3) @(posedge sys_clk);
    q.push_back('{cyc + 2, 52'h3000000, {26'h0, p, 1'b1, 24'h0}});
  endtask
  task automatic set_dis(input logic d);
    @(posedge sys_clk);
    mem_disable_wr    <= 1'b1;
    mem_disable_wdata <= d;
    @(posedge sys_clk);
    mem_disable_wr <= 1'b0;
    // the bit only moves in processor mode
    if (mp_e)
      dis_e = d;
  endtask
  task automatic phase(input string name);
    foreach (tbl[i]) go(tbl[i]);
    repeat (24) go(16'($random(seed)));
    repeat (3) @(posedge sys_clk);
    $display("test %s done", name);
  endtask
  // watcher: every note due by this cycle is compared against the pins
  always @(negedge sys_clk) begin
    logic [51:0] got;
    got = {ext_busy, ext_selected, port_a_oe, port_a_out, ext_rdata,
           microprocessor_mode, mem_disable, port_d_out, port_b_out, port_c_out};
    while (q.size() > 0 && q[0].cyc <= cyc) begin
      n_compared++;
      if ((got & q[0].msk) !== (q[0].exp & q[0].msk)) begin
        n_mismatch++;
        $display("[FAIL] pins exp %h got %h", q[0].exp & q[0].msk, got & q[0].msk);
      end
      void'(q.pop_front());
    end
  end
  initial begin
    restart(1'b0);
    phase("microcomputer");
    set_dis(1'b0);
    @(posedge sys_clk);
    mode_select_pin <= 1'b1;
    phase("pin moved");
    restart(1'b1);
    phase("processor");
    set_dis(1'b0);
    phase("internal memory");
    set_dis(1'b1);
    go(16'h7FFE);
    repeat (3) @(posedge sys_clk);
    end_of_test();
  end
endmodule
